// ---- inc/bcm_params.svh ----
// Purpose: Shared constants for the branch, call and indexed-move execution block
// Assumes: Included by bare name from every design file
// Notes: Definitions only; indirect register windows are plain defaults
`ifndef BCM_PARAMS_SVH
`define BCM_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define BCM_PC_W 21
`define BCM_ADDR_W 12

// ----------------------------------------------------------------
// Phases of one instruction cycle
// ----------------------------------------------------------------
`define BCM_Q1 2'h0
`define BCM_Q2 2'h1
`define BCM_Q3 2'h2
`define BCM_Q4 2'h3

// ----------------------------------------------------------------
// Opcodes and fields
// ----------------------------------------------------------------
`define BCM_OP_BNZ 8'hE1
`define BCM_OP_CALL_VIA_WORKING_REG 16'h0014
`define BCM_OP_MOVE1 8'hEB
`define BCM_OP_MOVE2 4'hF

// ----------------------------------------------------------------
// Program counter step and reset values
// ----------------------------------------------------------------
`define BCM_PC_STEP 21'h0_0002
`define BCM_RST_PC 21'h0_0000
`define BCM_RST_WORD 16'h0000
`define BCM_RST_ADDR 12'h000
`define BCM_RST_DATA 8'h00
`define BCM_IND_DATA 8'h00

// ----------------------------------------------------------------
// Indirect register windows: top address of each, five registers each
// ----------------------------------------------------------------
`define BCM_IND_TOP0 12'hFEF
`define BCM_IND_TOP1 12'hFE7
`define BCM_IND_TOP2 12'hFDF
`define BCM_IND_SPAN 12'h004

`endif

// ---- inc/bcm_pkg.sv ----
// Purpose: Types for the branch, call and indexed-move execution block
// Assumes: Nothing beyond the constants header
// Notes: States carry explicit binary codes
package bcm_pkg;
  // Execution state per instruction cycle
  typedef enum logic [1:0] {
    BCM_ST_EXEC = 2'b00,
    BCM_ST_NOP = 2'b01,
    BCM_ST_MOVE2 = 2'b10
  } bcm_state_t;
  // Phase counter type
  typedef logic [1:0] bcm_phase_t;
endpackage

// ---- hdl/bcm_branch_target.sv ----
// Purpose: Sequential and relative branch target adders
// Assumes: pc_cur is the address of the instruction being executed
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
`include "bcm_params.svh"

module bcm_branch_target #(
  parameter int PC_W = `BCM_PC_W
) (
  input wire logic [PC_W-1:0] pc_cur,
  input wire logic [7:0] offset,
  output logic [PC_W-1:0] seq_pc,
  output logic [PC_W-1:0] branch_pc
);
  // ----------------------------------------------------------------
  // Adders
  // ----------------------------------------------------------------
  // Signed offset doubled to a word displacement
  logic [PC_W-1:0] disp;
  assign disp = {{(PC_W-9){offset[7]}}, offset, 1'b0};
  // Next word address
  assign seq_pc = pc_cur + PC_W'(`BCM_PC_STEP);
  // Incremented PC plus doubled offset, wraps modulo PC width
  assign branch_pc = seq_pc + disp;
endmodule
`default_nettype wire

// ---- hdl/bcm_src_fetch.sv ----
// Purpose: Source address of the indexed move and its captured read data
// Assumes: Memory read data is valid while the read strobe is high
// Notes: Indirect register hits read as zero
`timescale 1ns/1ps
`default_nettype none
`include "bcm_params.svh"

module bcm_src_fetch (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic calc,
  input wire logic capture,
  input wire logic [11:0] base,
  input wire logic [6:0] offset,
  input wire logic [7:0] rd_data,
  output logic [11:0] src_addr,
  output logic src_indirect,
  output logic [7:0] src_data
);
  // ----------------------------------------------------------------
  // Address and indirect detect
  // ----------------------------------------------------------------
  // Pointer plus offset, cut to the 4096-byte space
  logic [11:0] sum;
  // Window tops
  logic [11:0] tops [3];
  // Per-window hit
  logic [2:0] hit;
  assign sum = base + {5'h00, offset};
  assign tops[0] = `BCM_IND_TOP0;
  assign tops[1] = `BCM_IND_TOP1;
  assign tops[2] = `BCM_IND_TOP2;
  for (genvar i = 0; i < 3; i++) begin : g_win
    assign hit[i] = (sum <= tops[i]) && (sum >= tops[i] - `BCM_IND_SPAN);
  end

  // Register the address and its class during the address phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_addr <= `BCM_RST_ADDR;
      src_indirect <= 1'b0;
    end else if (calc) begin
      src_addr <= sum;
      src_indirect <= |hit;
    end
  end

  // ----------------------------------------------------------------
  // Data capture
  // ----------------------------------------------------------------
  // Indirect registers give zero instead of memory data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_data <= `BCM_RST_DATA;
    end else if (capture) begin
      src_data <= src_indirect ? `BCM_IND_DATA : rd_data;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/bcm_exec.sv ----
// Purpose: Execute branch-on-nonzero, call-via-working-reg and indexed move
// Assumes: Four clk phases per instruction cycle; words offered in Q1
// Notes: Strobes are registered and stand for one phase, except fetch_flush, which stands for a whole cycle
//
// Behaviour
// - Nonzero branch jumps to PC+2+2n, n signed byte
// - Branch takes one cycle, two when taken
// - Call pushes PC+2 onto return stack first
// - Call loads PC from working reg and latches
// - Call takes two cycles, second is idle
// - Call never touches working, status, bank regs
// - Move source is third pointer plus offset
// - Move destination is second-word 12-bit literal
// - Both move addresses span full 4096 bytes
// - Indirect register source reads as zero
// - Move decodes two words, takes two cycles unless the second word is late
// - Move second cycle dummy reads then writes
`timescale 1ns/1ps
`default_nettype none
`include "bcm_params.svh"

module bcm_exec #(
  parameter int PC_W = `BCM_PC_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  input wire logic [PC_W-1:0] pc,
  input wire logic zero_flag,
  input wire logic [7:0] working_register,
  input wire logic [7:0] pc_high_latch,
  input wire logic [7:0] pc_upper_latch,
  input wire logic [11:0] third_pointer_reg,
  input wire logic [7:0] mem_rd_data,
  output logic pc_load,
  output logic [PC_W-1:0] pc_next,
  output logic stack_push,
  output logic [PC_W-1:0] stack_push_data,
  output logic fetch_flush,
  output logic mem_rd_en,
  output logic [11:0] mem_rd_addr,
  output logic mem_wr_en,
  output logic [11:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  output bcm_pkg::bcm_phase_t phase
);
  import bcm_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bcm_state_t st; // Current cycle kind
  bcm_state_t next_st; // Kind of the following cycle
  logic [15:0] ir; // First instruction word
  logic ir_ok; // First word was offered
  logic [15:0] ir2; // Second word of the move
  logic ir2_ok; // Second word was offered
  logic [PC_W-1:0] pc_cur; // Address of the word in execution
  logic [PC_W-1:0] seq_pc; // Next word address
  logic [PC_W-1:0] branch_pc; // Relative branch target
  logic [PC_W-1:0] call_pc; // Computed call target
  logic dec_bnz; // Branch-on-nonzero decoded
  logic dec_call; // Call-via-working-reg decoded
  logic dec_move; // Indexed move first word decoded
  logic word2_good; // Second word carries its marker
  logic bnz_take; // Branch condition met
  logic src_indirect; // Source hits an indirect register
  logic [7:0] src_data; // Captured source byte
  logic exec_go; // Valid first-cycle instruction
  logic move2_go; // Valid move second cycle

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign dec_bnz = (ir[15:8] == `BCM_OP_BNZ);
  assign dec_call = (ir == `BCM_OP_CALL_VIA_WORKING_REG);
  assign dec_move = (ir[15:8] == `BCM_OP_MOVE1) && !ir[7];
  assign word2_good = (ir2[15:12] == `BCM_OP_MOVE2);
  assign bnz_take = dec_bnz && !zero_flag;
  assign exec_go = (st == BCM_ST_EXEC) && ir_ok;
  assign move2_go = (st == BCM_ST_MOVE2) && ir2_ok;
  // Working reg feeds only the low byte; no other register is saved
  assign call_pc = PC_W'({pc_upper_latch, pc_high_latch, working_register});
  // Fetch offers a word in every Q1
  assign instr_ready = (phase == `BCM_Q1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  bcm_branch_target #(
    .PC_W(PC_W)
  ) u_target (
    .pc_cur(pc_cur),
    .offset(ir[7:0]),
    .seq_pc(seq_pc),
    .branch_pc(branch_pc)
  );

  bcm_src_fetch u_src (
    .clk(clk),
    .sys_rst(sys_rst),
    .calc(exec_go && dec_move && (phase == `BCM_Q2)),
    .capture(exec_go && dec_move && (phase == `BCM_Q4)),
    .base(third_pointer_reg),
    .offset(ir[6:0]),
    .rd_data(mem_rd_data),
    .src_addr(mem_rd_addr),
    .src_indirect(src_indirect),
    .src_data(src_data)
  );

  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  // Free-running Q1..Q4
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= `BCM_Q1;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Instruction capture
  // ----------------------------------------------------------------
  // Words taken at the end of Q1; idle cycles drop the fetched word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ir <= `BCM_RST_WORD;
      ir_ok <= 1'b0;
      ir2 <= `BCM_RST_WORD;
      ir2_ok <= 1'b0;
      pc_cur <= PC_W'(`BCM_RST_PC);
    end else if (phase == `BCM_Q1) begin
      if (st == BCM_ST_EXEC) begin
        ir <= instr_word;
        ir_ok <= instr_valid;
        pc_cur <= pc;
      end else if (st == BCM_ST_MOVE2) begin
        ir2 <= instr_word;
        ir2_ok <= instr_valid;
        pc_cur <= pc;
      end else begin
        ir_ok <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    case (st)
      BCM_ST_EXEC: begin
        if (!ir_ok) begin
          next_st = BCM_ST_EXEC;
        end else if (bnz_take || dec_call) begin
          next_st = BCM_ST_NOP;
        end else if (dec_move) begin
          next_st = BCM_ST_MOVE2;
        end else begin
          next_st = BCM_ST_EXEC;
        end
      end
      BCM_ST_MOVE2: begin
        // Wait here while the second word is missing
        next_st = ir2_ok ? BCM_ST_EXEC : BCM_ST_MOVE2;
      end
      BCM_ST_NOP: begin
        next_st = BCM_ST_EXEC;
      end
      default: begin
        next_st = BCM_ST_EXEC;
      end
    endcase
  end

  // State and flush advance at the end of Q4
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= BCM_ST_EXEC;
      fetch_flush <= 1'b0;
    end else if (phase == `BCM_Q4) begin
      st <= next_st;
      fetch_flush <= (next_st == BCM_ST_NOP);
    end
  end

  // ----------------------------------------------------------------
  // Program counter update, visible in Q4
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_load <= 1'b0;
      pc_next <= PC_W'(`BCM_RST_PC);
    end else if (phase == `BCM_Q3) begin
      pc_load <= exec_go || move2_go;
      if (exec_go && dec_call) begin
        pc_next <= call_pc;
      end else if (exec_go && bnz_take) begin
        pc_next <= branch_pc;
      end else begin
        pc_next <= seq_pc;
      end
    end else begin
      pc_load <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Return stack push, visible in Q3
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stack_push <= 1'b0;
      stack_push_data <= PC_W'(`BCM_RST_PC);
    end else begin
      stack_push <= exec_go && dec_call && (phase == `BCM_Q2);
      if (exec_go && dec_call && (phase == `BCM_Q2)) begin
        stack_push_data <= seq_pc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data memory strobes
  // ----------------------------------------------------------------
  // Source read in Q4 of cycle one, dummy read in Q2 of cycle two
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_rd_en <= 1'b0;
    end else begin
      mem_rd_en <= (exec_go && dec_move && (phase == `BCM_Q3))
        || ((st == BCM_ST_MOVE2) && (phase == `BCM_Q1));
    end
  end

  // Destination written in Q4; destination is not screened
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_wr_en <= 1'b0;
      mem_wr_addr <= `BCM_RST_ADDR;
      mem_wr_data <= `BCM_RST_DATA;
    end else if (phase == `BCM_Q3) begin
      mem_wr_en <= move2_go && word2_good;
      if (move2_go && word2_good) begin
        mem_wr_addr <= ir2[11:0];
        mem_wr_data <= src_data;
      end
    end else begin
      mem_wr_en <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_bnz_taken_target: assert property (
    (phase == `BCM_Q3 && exec_go && dec_bnz && !zero_flag)
      |=> pc_load && pc_next == $past(branch_pc))
    else $error("taken branch target wrong");

  a_bnz_taken_cycles: assert property (
    (phase == `BCM_Q4 && exec_go && dec_bnz && !zero_flag)
      |=> fetch_flush [*4] ##1 !fetch_flush)
    else $error("taken branch not two cycles");

  a_bnz_fall_through: assert property (
    (phase == `BCM_Q3 && exec_go && dec_bnz && zero_flag)
      |=> pc_load && pc_next == $past(pc_cur) + PC_W'(`BCM_PC_STEP) ##1 !fetch_flush)
    else $error("untaken branch not sequential");

  a_call_push: assert property (
    (phase == `BCM_Q2 && exec_go && dec_call)
      |=> stack_push && stack_push_data == $past(pc_cur) + PC_W'(`BCM_PC_STEP)
      ##1 !stack_push && pc_load)
    else $error("call push wrong");

  a_call_target: assert property (
    (phase == `BCM_Q3 && exec_go && dec_call)
      |=> pc_load && pc_next[7:0] == $past(working_register)
      && pc_next[15:8] == $past(pc_high_latch))
    else $error("call target wrong");

  a_call_idle_cycle: assert property (
    (phase == `BCM_Q4 && exec_go && dec_call)
      |=> (fetch_flush && !pc_load && !stack_push) [*4])
    else $error("call second cycle not idle");

  a_move_source: assert property (
    (phase == `BCM_Q2 && exec_go && dec_move)
      |=> ##1 mem_rd_en && mem_rd_addr == 12'($past(third_pointer_reg, 2)
      + {5'h00, $past(ir[6:0], 2)}))
    else $error("move source address wrong");

  a_move_dest: assert property (
    (phase == `BCM_Q3 && move2_go && word2_good)
      |=> mem_wr_en && mem_wr_addr == $past(ir2[11:0]) && !mem_rd_en)
    else $error("move destination wrong");

  a_move_dummy_read: assert property (
    (st == BCM_ST_MOVE2 && phase == `BCM_Q2)
      |-> mem_rd_en && !mem_wr_en && !pc_load && !stack_push)
    else $error("move second cycle middle phase wrong");

  a_move_indirect_zero: assert property (
    (mem_wr_en && src_indirect) |-> mem_wr_data == `BCM_IND_DATA)
    else $error("indirect source not zero");

  a_move_two_cycle: assert property (
    (phase == `BCM_Q4 && exec_go && dec_move) |=> st == BCM_ST_MOVE2)
    else $error("move not two cycles");

  c_bnz_taken: cover property (pc_load && fetch_flush == 1'b0 && $past(bnz_take));
  c_bnz_not_taken: cover property (phase == `BCM_Q4 && exec_go && dec_bnz && zero_flag);
  c_call: cover property (stack_push ##1 pc_load);
  c_move_write: cover property (mem_wr_en && src_indirect);
endmodule
`default_nettype wire

// ---- tb/bcm_data_mem.sv ----
// Purpose: Data memory partner facing the execution block
// Assumes: Read data is only needed while the read strobe is high
// Notes: Unselected read lines show the inverse of the last value read
`timescale 1ns/1ps
`default_nettype none
`include "bcm_params.svh"

module bcm_data_mem (
  input wire logic clk,
  input wire logic rd_en,
  input wire logic [11:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [11:0] wr_addr,
  input wire logic [7:0] wr_data
);
  // ------------------------------------------------
  // Storage
  // ------------------------------------------------
  logic [7:0] mem [4096];
  logic [7:0] last; // Last value put on the read lines

  // Known fill so the bench can predict any source byte
  initial begin
    last = 8'h00;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end

  // Unselected lines must not keep the old value
  assign rd_data = rd_en ? mem[rd_addr] : ~last;

  // Remember reads; take writes on the rising edge
  always @(posedge clk) begin
    if (rd_en) begin
      last <= mem[rd_addr];
    end
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule
`default_nettype wire

// ---- tb/bcm_exec_test.sv ----
// Purpose: Self-checking bench for the branch, call and indexed-move block
// Assumes: One word taken per four-clock cycle, at the edge with phase zero
// Notes: Inputs change on the falling edge; outputs counted there too
`timescale 1ns/1ps
`default_nettype none
`include "bcm_params.svh"

module bcm_exec_test;
  import bcm_pkg::*;
  // ------------------------------------------------
  // Table row: stimulus and expected outcome
  // ------------------------------------------------
  typedef struct {
    logic [15:0] w1;
    logic [15:0] w2;
    logic [20:0] pcv;
    logic zf;
    logic [11:0] ptr;
    logic [20:0] nxt;
    int nl;
    int fl;
    int np;
    int nw;
    logic [11:0] wa;
    logic [7:0] wd;
  } bcm_row_t;
  // Move destinations stay clear of PC low and stack top bytes
  bcm_row_t rows [8] = '{
    '{16'hE105, 16'hE100, 21'h0_0100, 1'b0, 12'h000, 21'h0_010C, 1, 4, 0, 0, 12'h000, 8'h00},
    '{16'hE180, 16'hE100, 21'h0_1000, 1'b0, 12'h000, 21'h0_0F02, 1, 4, 0, 0, 12'h000, 8'h00},
    '{16'hE17F, 16'hE100, 21'h0_0200, 1'b0, 12'h000, 21'h0_0300, 1, 4, 0, 0, 12'h000, 8'h00},
    '{16'hE105, 16'h0000, 21'h0_0300, 1'b1, 12'h000, 21'h0_0302, 1, 0, 0, 0, 12'h000, 8'h00},
    '{16'h0014, 16'hE100, 21'h0_0400, 1'b0, 12'h000, 21'h3_125A, 1, 4, 1, 0, 12'h000, 8'h00},
    '{16'hEB05, 16'hF123, 21'h0_0500, 1'b0, 12'h080, 21'h0_0504, 2, 0, 0, 1, 12'h123, 8'hDF},
    '{16'hEB7F, 16'hF000, 21'h0_0800, 1'b0, 12'hF80, 21'h0_0804, 2, 0, 0, 1, 12'h000, 8'hA5},
    '{16'hEB0F, 16'hFABC, 21'h0_0900, 1'b0, 12'hFE0, 21'h0_0904, 2, 0, 0, 1, 12'hABC, 8'h00}
  };
  logic clk, sys_rst, instr_valid, instr_ready, zero_flag;
  logic [15:0] instr_word;
  logic [20:0] pc, pc_next, stack_push_data;
  logic [7:0] working_register, pc_high_latch, pc_upper_latch;
  logic [11:0] third_pointer_reg, mem_rd_addr, mem_wr_addr;
  logic [7:0] mem_rd_data, mem_wr_data;
  logic pc_load, stack_push, fetch_flush, mem_rd_en, mem_wr_en;
  bcm_phase_t phase;
  int num_errors, checked; // Mismatches and comparisons
  int n_load, n_push, n_flush, n_rd, n_wr; // Pulse counts per run
  logic [20:0] last_nxt, last_push; // Last PC load and push values
  logic [11:0] last_wa; // Last write address
  logic [11:0] last_ra; // Last read address
  logic [7:0] last_wd; // Last write data

  // ------------------------------------------------
  // Design, partner and clock
  // ------------------------------------------------
  bcm_exec dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .pc(pc), .zero_flag(zero_flag),
    .working_register(working_register), .pc_high_latch(pc_high_latch),
    .pc_upper_latch(pc_upper_latch), .third_pointer_reg(third_pointer_reg),
    .mem_rd_data(mem_rd_data), .pc_load(pc_load), .pc_next(pc_next),
    .stack_push(stack_push), .stack_push_data(stack_push_data),
    .fetch_flush(fetch_flush), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .phase(phase));
  bcm_data_mem mem (.clk(clk), .rd_en(mem_rd_en), .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data), .wr_en(mem_wr_en), .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data));
  always #5 clk = ~clk;

  // Count settled pulses at each falling edge
  always @(negedge clk) begin
    if (pc_load === 1'b1) begin
      n_load++;
      last_nxt = pc_next;
    end
    if (stack_push === 1'b1) begin
      n_push++;
      last_push = stack_push_data;
    end
    if (mem_wr_en === 1'b1) begin
      n_wr++;
      last_wa = mem_wr_addr;
      last_wd = mem_wr_data;
    end
    n_flush += (fetch_flush === 1'b1);
    n_rd += (mem_rd_en === 1'b1);
    if (mem_rd_en === 1'b1) begin
      last_ra = mem_rd_addr;
    end
  end

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Wait, bounded, for the falling edge before a take edge
  task automatic align();
    int i;
    i = 0;
    while (phase !== `BCM_Q1 && i < 8) begin
      @(negedge clk);
      i++;
    end
    if (phase !== `BCM_Q1) begin
      chk("phase alignment", phase, 0);
      conclude();
    end
    // Fetch may only hand over a word in the take phase
    chk("instr ready", instr_ready, 1'b1);
    n_load = 0;
    n_push = 0;
    n_flush = 0;
    n_rd = 0;
    n_wr = 0;
  endtask

  // Offer the first word, the second in the next cycle only if nonzero, then watch two idle cycles
  task automatic run(input logic [15:0] a, input logic [15:0] b, input logic [20:0] p,
                     input logic z);
    align();
    zero_flag = z;
    instr_valid = 1'b1;
    instr_word = a;
    pc = p;
    repeat (4) @(negedge clk);
    instr_valid = (b !== 16'h0000);
    instr_word = b;
    pc = p + `BCM_PC_STEP;
    repeat (4) @(negedge clk);
    instr_valid = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    pc = 21'h0_0000;
    zero_flag = 1'b0;
    working_register = 8'h5A;
    pc_high_latch = 8'h12;
    pc_upper_latch = 8'h03;
    third_pointer_reg = 12'h000;
    num_errors = 0;
    checked = 0;
    repeat (12) @(negedge clk);
    // Quiet outputs while held in reset
    chk("reset phase", phase, 0);
    chk("reset strobes", {pc_load, stack_push, fetch_flush, mem_rd_en, mem_wr_en}, 0);
    sys_rst = 1'b0;
    // Ordinary cases from the table
    foreach (rows[k]) begin
      third_pointer_reg = rows[k].ptr;
      run(rows[k].w1, rows[k].w2, rows[k].pcv, rows[k].zf);
      chk("pc loads", n_load, rows[k].nl);
      chk("next pc", last_nxt, rows[k].nxt);
      chk("flush clocks", n_flush, rows[k].fl);
      chk("pushes", n_push, rows[k].np);
      chk("writes", n_wr, rows[k].nw);
      if (rows[k].np != 0) begin
        chk("push data", last_push, rows[k].pcv + `BCM_PC_STEP);
      end
      if (rows[k].nw != 0) begin
        chk("reads", n_rd, 2);
        chk("read addr", last_ra, 12'(rows[k].ptr + rows[k].w1[6:0]));
        chk("write addr", last_wa, rows[k].wa);
        chk("write data", last_wd, rows[k].wd);
      end
    end
    // Second move word without its marker nibble writes nothing
    third_pointer_reg = 12'h080;
    run(16'hEB05, 16'h0123, 21'h0_0600, 1'b0);
    chk("bad word writes", n_wr, 0);
    chk("bad word loads", n_load, 2);
    chk("bad word next pc", last_nxt, 21'h0_0604);
    // Second move word arrives late; the move waits and then completes
    run(16'hEB05, 16'h0000, 21'h0_0B00, 1'b0);
    chk("late word loads", n_load, 1);
    chk("late word writes", n_wr, 0);
    run(16'hF0C0, 16'h0000, 21'h0_0B02, 1'b0);
    chk("late word write count", n_wr, 1);
    chk("late write addr", last_wa, 12'h0C0);
    chk("late write data", last_wd, 8'hDF);
    chk("late next pc", last_nxt, 21'h0_0B04);
    // Reset lands in the middle of a call, before its push
    align();
    instr_valid = 1'b1;
    instr_word = `BCM_OP_CALL_VIA_WORKING_REG;
    pc = 21'h0_0A00;
    // Half a clock after the take edge: the push would come at the next edge
    repeat (1) @(negedge clk);
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk("aborted pushes", n_push, 0);
    chk("aborted loads", n_load, 0);
    // Recovery with an untaken branch
    run(16'hE105, 16'h0000, 21'h0_0700, 1'b1);
    chk("recovered next pc", last_nxt, 21'h0_0702);
    chk("recovered flush", n_flush, 0);
    conclude();
  end
endmodule
`default_nettype wire
